/* File: design/sac_pkg.sv */
// package for the serial converter command block: command codes, format fields, timing
// assumes a 250 MHz system clock; the conversion count CONV_COUNT is in system clock cycles, the edge counts in shift clock edges
package sac_pkg;
   // command codes (upper nibble of the command byte)
   localparam logic [3:0] CMD_LAST_CHANNEL = 4'ha;  // channels 0..10
   localparam logic [3:0] CMD_TEST_MID     = 4'hb;  // reference midpoint
   localparam logic [3:0] CMD_TEST_LOW     = 4'hc;  // low_ref_test_level
   localparam logic [3:0] CMD_TEST_HIGH    = 4'hd;  // high_ref_test_level
   localparam logic [3:0] CMD_SLEEP        = 4'he;  // software_sleep
   localparam logic [3:0] CMD_RESERVED     = 4'hf;
   // output_format_config field positions
   localparam int         FMT_LEN_HI       = 3;
   localparam int         FMT_LEN_LO       = 2;
   localparam int         FMT_LSB_FIRST    = 1;
   localparam int         FMT_TWOS         = 0;
   localparam logic [3:0] FMT_RESET        = 4'h0;
   // length codes
   localparam logic [1:0] LEN_8            = 2'h1;
   localparam logic [1:0] LEN_16           = 2'h3;
   localparam logic [4:0] BITS_8           = 5'h08;
   localparam logic [4:0] BITS_12          = 5'h0c;
   localparam logic [4:0] BITS_16          = 5'h10;
   localparam logic [4:0] SAMPLE_EDGE      = 5'h04;  // sampling starts after this fall
   localparam logic [4:0] LEN_TAKE_RISE    = 5'h06;  // new length effective here
   localparam logic [4:0] CMD_BITS         = 5'h08;  // command byte length
   // conversion timing: 13.5 oscillator periods plus a start delay
   localparam int         OSC_PERIOD_NS    = 40;     // internal_oscillator period
   localparam int         CLK_PERIOD_NS    = 4;
   localparam int         START_DELAY_NS   = 25;
   localparam int         CONV_HALF_OSC    = 27;     // 13.5 periods in half periods
   localparam int         CONV_NS          = CONV_HALF_OSC * OSC_PERIOD_NS / 2
                                             + START_DELAY_NS;
   localparam int         CONV_CYCLES      = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] CONV_COUNT       = 10'(CONV_CYCLES);
   // result fifo
   localparam int         FIFO_WIDTH       = 12;
   localparam int         FIFO_DEPTH       = 8;
endpackage

/* File: design/sac_fifo.sv */
// fifo with valid/ready on both sides; carries converted results to the output buffer
// assumes one clock domain, synchronous use
`timescale 1ns/10ps
module sac_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW:0]      wr_ff;        // write pointer with wrap bit
   logic [AW:0]      rd_ff;        // read pointer with wrap bit
   logic             push;
   logic             pop;

   // honest flags from pointer compare
   assign out_valid = (wr_ff != rd_ff);
   assign in_ready  = (wr_ff[AW-1:0] != rd_ff[AW-1:0]) || (wr_ff[AW] == rd_ff[AW]);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ff[AW-1:0]];

   // pointers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ff <= wr_ff + 1'b1;
         if (pop)
            rd_ff <= rd_ff + 1'b1;
      end
   end

   // storage has no reset; contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ff[AW-1:0]] <= in_data;
   end
endmodule

/* File: design/sac_core.sv */
// serial converter command and output sequencer: command byte, format, eoc, result shift
// assumes shift clock, select and command input come from the host, asynchronous to CLK;
// the analog core delivers a 12-bit code in RESULT_CODE, sampled when conversion ends
`timescale 1ns/10ps
module sac_core
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        SEL_N,         // host select, active low
   input  wire logic        SHIFT_CLK,     // host shift clock
   input  wire logic        SERIAL_CMD_BITS, // command input
   input  wire logic [11:0] RESULT_CODE,   // code from the analog core
   output logic             SDO_O,         // serial output value
   output logic             SDO_OE_N,      // low while driving the output
   output logic             EOC,           // end of conversion
   output logic             SAMPLE,        // sampling switch closed
   output logic [3:0]       MUX_SEL,       // input selected for conversion
   output logic             SOFTWARE_SLEEP, // sleep of analog and reference
   output logic [3:0]       FMT_OUT        // output_format_config readback
);
   import sac_pkg::*;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,   // waiting for select
      ST_IO   = 2'b01,   // i/o cycle running
      ST_CONV = 2'b10    // converting
   } sac_state_t;

   // synchronisers; first stage read only by the second
   logic [1:0]  sck_sync_ff;
   logic [1:0]  sel_sync_ff;
   logic [1:0]  din_sync_ff;
   logic        sck_last_ff;     // previous synced clock, for edges
   logic        sel_last_ff;
   logic        rise;
   logic        fall;
   logic        sel_fall;
   logic        sel_n;

   sac_state_t  state_ff;
   logic [7:0]  command_input_register_ff;  // shift register
   logic [3:0]  output_format_config_ff;    // length, order, coding
   logic [4:0]  rise_cnt_ff;                // rising edges this cycle
   logic [4:0]  fall_cnt_ff;                // falling edges this cycle
   logic [1:0]  cyc_len_ff;                 // length governing this cycle
   logic        cyc_lsb_ff;                 // bit order of this cycle
   logic        conv_twos_ff;               // coding for pending conversion
   logic [3:0]  conv_sel_ff;                // input for pending conversion
   logic [9:0]  conv_cnt_ff;                // conversion timer
   logic [15:0] out_sr_ff;                  // output shifter
   logic [11:0] out_buf_ff;                 // last completed result
   logic        eoc_ff;
   logic        sample_ff;
   logic        sdo_ff;
   logic        oe_n_ff;
   logic        sleep_ff;
   logic [4:0]  last_edge;
   logic        nxt_sleep;                  // sleep as the fourth fall will leave it
   logic        buf_load;                   // buffer takes the fifo head this cycle
   logic [11:0] coded;
   logic [15:0] frame;
   logic        conv_done;
   logic        fifo_ready;
   logic        fifo_valid;
   logic [11:0] fifo_data;

   assign rise     = sck_sync_ff[1] & ~sck_last_ff;
   assign fall     = ~sck_sync_ff[1] & sck_last_ff;
   assign sel_n    = sel_sync_ff[1];
   assign sel_fall = ~sel_sync_ff[1] & sel_last_ff;

   // two-flop synchronisers for every host pin
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sck_sync_ff <= 2'h0;
         sel_sync_ff <= 2'h3;
         din_sync_ff <= 2'h0;
         sck_last_ff <= 1'b0;
         sel_last_ff <= 1'b1;
      end
      else
      begin
         sck_sync_ff <= {sck_sync_ff[0], SHIFT_CLK};
         sel_sync_ff <= {sel_sync_ff[0], SEL_N};
         din_sync_ff <= {din_sync_ff[0], SERIAL_CMD_BITS};
         sck_last_ff <= sck_sync_ff[1];
         sel_last_ff <= sel_sync_ff[1];
      end
   end

   // final falling edge by the length of this cycle
   always_comb
   begin
      case (cyc_len_ff)
         LEN_8:   last_edge = BITS_8;
         LEN_16:  last_edge = BITS_16;
         default: last_edge = BITS_12;
      endcase
   end

   // sleep that the nibble now in the shifter selects; meaningful only at the fourth fall
   assign nxt_sleep = (command_input_register_ff[3:0] == CMD_SLEEP)
                      || (command_input_register_ff[3:0] == CMD_RESERVED && sleep_ff);
   assign conv_done = (state_ff == ST_CONV) && (conv_cnt_ff == 10'h000);

   // sequencer
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         state_ff <= ST_IDLE;
      else if (sel_n)
         state_ff <= ST_IDLE;                         // select high aborts all
      else
      begin
         case (state_ff)
            ST_IDLE:
               state_ff <= ST_IO;
            ST_IO:
               if (fall && (fall_cnt_ff + 5'h01 == last_edge))
                  state_ff <= sleep_ff ? ST_IO : ST_CONV;
            ST_CONV:
               if (conv_done)
                  state_ff <= ST_IO;
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   // edge counters cleared outside ST_IO; fall count also wraps at the last edge, rise count does not
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         rise_cnt_ff <= 5'h00;
         fall_cnt_ff <= 5'h00;
      end
      else if (state_ff != ST_IO)
      begin
         rise_cnt_ff <= 5'h00;
         fall_cnt_ff <= 5'h00;
      end
      else
      begin
         if (rise)
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
         if (fall)
            fall_cnt_ff <= (fall_cnt_ff + 5'h01 == last_edge) ? 5'h00
                           : fall_cnt_ff + 5'h01;
      end
   end

   // command capture, only the first eight rising edges
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         command_input_register_ff <= 8'h00;
      else if (state_ff == ST_IO && rise && rise_cnt_ff < CMD_BITS)
         command_input_register_ff <= {command_input_register_ff[6:0], din_sync_ff[1]};
   end

   // format register, loaded at the end of the byte unless reserved
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         output_format_config_ff <= FMT_RESET;
      else if (state_ff == ST_IO && rise && rise_cnt_ff == CMD_BITS - 5'h01
               && command_input_register_ff[6:3] != CMD_RESERVED)
         output_format_config_ff <= {command_input_register_ff[2:0], din_sync_ff[1]};
   end

   // length taken early; order and coding only from the next cycle
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         cyc_len_ff <= FMT_RESET[FMT_LEN_HI:FMT_LEN_LO];
         cyc_lsb_ff <= 1'b0;
      end
      else if (state_ff != ST_IO)
         cyc_lsb_ff <= output_format_config_ff[FMT_LSB_FIRST];
      else if (rise && rise_cnt_ff == LEN_TAKE_RISE - 5'h01
               && command_input_register_ff[4:1] != CMD_RESERVED)
         cyc_len_ff <= {command_input_register_ff[0], din_sync_ff[1]};
   end

   // command nibble and coding latched for the following conversion
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         conv_sel_ff  <= 4'h0;
         conv_twos_ff <= 1'b0;
         sleep_ff     <= 1'b1;   // sleeps until first valid address
      end
      else if (state_ff == ST_IO && fall && fall_cnt_ff == SAMPLE_EDGE - 5'h01)
      begin
         if (command_input_register_ff[3:0] == CMD_SLEEP)
            sleep_ff <= 1'b1;
         else if (command_input_register_ff[3:0] != CMD_RESERVED)
         begin
            sleep_ff    <= 1'b0;
            conv_sel_ff <= command_input_register_ff[3:0];
         end
      end
      else if (state_ff == ST_IO && fall && fall_cnt_ff + 5'h01 == last_edge)
         conv_twos_ff <= output_format_config_ff[FMT_TWOS];
   end

   // sampling window from fourth to last falling edge
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         sample_ff <= 1'b0;
      else if (state_ff != ST_IO)
         sample_ff <= 1'b0;
      else if (fall && fall_cnt_ff + 5'h01 == last_edge)
         sample_ff <= 1'b0;                               // held at last fall
      else if (fall && fall_cnt_ff == SAMPLE_EDGE - 5'h01)
         sample_ff <= !nxt_sleep;                         // new command decides, not the old
   end

   // conversion timer on the oscillator-equivalent count
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         conv_cnt_ff <= CONV_COUNT;
      else if (state_ff != ST_CONV)
         conv_cnt_ff <= CONV_COUNT;
      else if (conv_cnt_ff != 10'h000)
         conv_cnt_ff <= conv_cnt_ff - 10'h001;
   end

   // eoc: high in reset, low during conversion
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         eoc_ff <= 1'b1;
      else if (state_ff == ST_IO && fall && fall_cnt_ff + 5'h01 == last_edge && !sleep_ff)
         eoc_ff <= 1'b0;
      else if (buf_load || sel_n)
         eoc_ff <= 1'b1;                                  // rises as the result lands
   end

   // coding applied as the result is latched
   assign coded = {RESULT_CODE[11] ^ conv_twos_ff, RESULT_CODE[10:0]};

   // buffer drains the fifo only while no cycle is in flight
   assign buf_load = fifo_valid && (state_ff != ST_IO || (fall_cnt_ff == 5'h00 && rise_cnt_ff == 5'h00));

   // result path through the fifo; the buffer drains it whenever a cycle is not in flight
   sac_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rst       (RST),
      .in_data   (coded),
      .in_valid  (conv_done),
      .in_ready  (fifo_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (buf_load)
   );

   // output buffer keeps the last completed result
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         out_buf_ff <= 12'h000;
      else if (buf_load)
         out_buf_ff <= fifo_data;
   end

   // frame in the order of this cycle; 16-bit pads zeros, 8-bit drops lsbs
   always_comb
   begin
      frame = {(buf_load ? fifo_data : out_buf_ff), 4'h0};  // fresh result bypass
      if (cyc_lsb_ff)
      begin
         frame = {<<{frame}};                             // lsb now at the top
         frame = frame << (5'h10 - last_edge);            // short lengths start at their lsb
      end
   end

   // serial output: first bit on cycle start, next bits on falling edges
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         out_sr_ff <= 16'h0000;
         sdo_ff    <= 1'b0;
         oe_n_ff   <= 1'b1;
      end
      else if (sel_n)
         oe_n_ff <= 1'b1;                                 // released; value kept, moves only on edges
      else if (state_ff == ST_CONV)
      begin
         oe_n_ff <= 1'b0;
         sdo_ff  <= 1'b0;                                 // forced low until eoc rises
      end
      else if ((state_ff == ST_IDLE && sel_fall) || (buf_load && state_ff == ST_IO && !eoc_ff))
      begin
         oe_n_ff   <= 1'b0;
         out_sr_ff <= frame << 1;
         sdo_ff    <= frame[15];
      end
      else if (state_ff == ST_IO && fall)
      begin
         // last fall starts a conversion unless sleep_ff is set: line goes low at once, not a leftover bit
         sdo_ff    <= (fall_cnt_ff + 5'h01 == last_edge) ? 1'b0 : out_sr_ff[15];
         out_sr_ff <= out_sr_ff << 1;
      end
   end

   assign SDO_O          = sdo_ff;
   assign SDO_OE_N       = oe_n_ff;
   assign EOC            = eoc_ff;
   assign SAMPLE         = sample_ff;
   assign MUX_SEL        = conv_sel_ff;
   assign SOFTWARE_SLEEP = sleep_ff;
   assign FMT_OUT        = output_format_config_ff;
endmodule

/* File: testbench/sac_core_chk.sv */
// checker for the converter command block: timing relations seen at its ports
// assumes it is bound to sac_core and watches ports only, one clock domain
`timescale 1ns/10ps
module sac_core_chk
(
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       SEL_N,
   input wire logic       SHIFT_CLK,
   input wire logic       SDO_O,
   input wire logic       SDO_OE_N,
   input wire logic       EOC,
   input wire logic       SAMPLE,
   input wire logic [3:0] FMT_OUT
);
   import sac_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   logic [9:0] eoc_low_ff;  // cycles spent converting so far
   // low time of eoc; wide enough that it never wraps within one conversion
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         eoc_low_ff <= 10'h000;
      else if (EOC)
         eoc_low_ff <= 10'h000;  // idle or sampling
      else
         eoc_low_ff <= eoc_low_ff + 10'h001;
   end
   property p_reset_state;
      $fell(RST) |-> EOC && FMT_OUT == FMT_RESET && SDO_OE_N;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_idle_hiz;
      SEL_N [*4] |-> SDO_OE_N;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while deselected");
   property p_sample_eoc;
      SAMPLE |-> EOC;
   endproperty
   a_sample_eoc: assert property (p_sample_eoc) else $error("eoc low while sampling");
   property p_eoc_fall;
      $fell(EOC) |-> !SAMPLE && ($past(SAMPLE) || $past(SAMPLE, 2));
   endproperty
   a_eoc_fall: assert property (p_eoc_fall) else $error("eoc fell without end of sampling");
   property p_conv_low;
      !EOC |-> !SDO_O;
   endproperty
   a_conv_low: assert property (p_conv_low) else $error("output not low in conversion");
   property p_conv_time;
      $rose(EOC) |-> eoc_low_ff >= CONV_COUNT - 10'h002 && eoc_low_ff <= CONV_COUNT + 10'h002;
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");
   property p_sdo_fall;
      $changed(SDO_O) && EOC && $past(EOC) |->
         ($past(SHIFT_CLK, 6) && !$past(SHIFT_CLK, 3)) || $past(SEL_N, 6) || $past(SEL_N, 4);
   endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("output moved off a falling edge");
   property p_fmt_change;
      $changed(FMT_OUT) |-> $past(SHIFT_CLK, 2) && !$past(SHIFT_CLK, 7);
   endproperty
   a_fmt_change: assert property (p_fmt_change) else $error("format moved off a rising edge");
   property p_sample_start;
      $rose(SAMPLE) |-> !SHIFT_CLK && $past(SHIFT_CLK, 6);
   endproperty
   a_sample_start: assert property (p_sample_start) else $error("sampling began off a fall");
endmodule

bind sac_core sac_core_chk chk_u (.CLK(CLK), .RST(RST), .SEL_N(SEL_N), .SHIFT_CLK(SHIFT_CLK),
   .SDO_O(SDO_O), .SDO_OE_N(SDO_OE_N), .EOC(EOC), .SAMPLE(SAMPLE), .FMT_OUT(FMT_OUT));

/* File: testbench/sac_host_model.sv */
// host serial port model: select, shift clock and command bits; collects the result
// assumes the bench clock paces it; shift clock half period is 6 clk (24 ns)
`timescale 1ns/10ps
module sac_host_model
(
   input  wire logic clk,
   input  wire logic sdo_o,
   input  wire logic sdo_oe_n,
   output logic      sel_n,
   output logic      shift_clk,
   output logic      cmd_bit
);
   logic sdo_line;  // level the host sees on the data line
   // a released line shows the inverse of the last value, never a stale copy
   assign sdo_line = sdo_oe_n ? ~sdo_o : sdo_o;
   initial
   begin
      sel_n     = 1'b1;
      shift_clk = 1'b0;  // stands low outside frames
      cmd_bit   = 1'b0;
   end
   // one I/O cycle of n clocks; rx[i] holds the i-th bit taken
   task automatic xfer(input logic [7:0] cmd, input int n, input logic keep,
                       output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      if (!keep)
      begin
         sel_n = 1'b1;  // toggle select between conversions
         repeat (8) @(negedge clk);
      end
      sel_n = 1'b0;
      repeat (8) @(negedge clk);  // select setup before the first edge
      for (i = 0; i < n; i++)  // exactly n clocks
      begin
         // msb first, then a toggling pattern the device must ignore
         cmd_bit = (i < 8) ? cmd[7 - i] : ~cmd_bit;
         repeat (6) @(negedge clk);
         shift_clk = 1'b1;
         rx[i]     = sdo_line;  // taken at the rising edge
         repeat (6) @(negedge clk);
         shift_clk = 1'b0;
      end
   endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the converter command block with a host model on its port
// assumes the design package and sac_core; RESULT_CODE stands in for the analog side
`timescale 1ns/10ps
module testbench;
   import sac_pkg::*;
   logic        CLK;
   logic        RST;
   logic [11:0] RESULT_CODE;
   wire         SEL_N, SHIFT_CLK, SERIAL_CMD_BITS, SDO_O, SDO_OE_N, EOC, SAMPLE, SOFTWARE_SLEEP;
   wire  [3:0]  MUX_SEL, FMT_OUT;
   int          num_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [3:0]  exp_fmt;    // expected format register
   logic [11:0] exp_res;    // coded result waiting in the buffer
   logic        res_ok;     // buffer content known
   logic        last_conv;  // previous cycle converted, select may stay low
   logic [4:0]  prev_n;

   sac_core dut_u (.CLK(CLK), .RST(RST), .SEL_N(SEL_N), .SHIFT_CLK(SHIFT_CLK),
      .SERIAL_CMD_BITS(SERIAL_CMD_BITS), .RESULT_CODE(RESULT_CODE), .SDO_O(SDO_O),
      .SDO_OE_N(SDO_OE_N), .EOC(EOC), .SAMPLE(SAMPLE), .MUX_SEL(MUX_SEL),
      .SOFTWARE_SLEEP(SOFTWARE_SLEEP), .FMT_OUT(FMT_OUT));
   sac_host_model host_u (.clk(CLK), .sdo_o(SDO_O), .sdo_oe_n(SDO_OE_N), .sel_n(SEL_N),
      .shift_clk(SHIFT_CLK), .cmd_bit(SERIAL_CMD_BITS));

   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   // hang guard, well above the expected run of about 12000 cycles
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // bits per cycle for a format nibble
   function automatic logic [4:0] len_bits(input logic [3:0] f);
      if (f[FMT_LEN_HI:FMT_LEN_LO] == LEN_8)
         return BITS_8;
      if (f[FMT_LEN_HI:FMT_LEN_LO] == LEN_16)
         return BITS_16;
      return BITS_12;  // low length bit clear
   endfunction

   // expected serial stream, s[i] is the i-th bit out
   function automatic logic [15:0] exp_stream(input logic [11:0] v, input logic [4:0] n,
                                              input logic lsb);
      logic [15:0] w;
      logic [15:0] s;
      s = 16'h0000;
      w = (n == BITS_8) ? {8'h00, v[11:4]} : (n == BITS_16) ? {v, 4'h0} : {4'h0, v};
      for (int i = 0; i < int'(n); i++)
         s[i] = lsb ? w[i] : w[int'(n) - 1 - i];
      return s;
   endfunction

   // one full I/O cycle plus whatever conversion it starts
   task automatic run(input logic [7:0] cmd, input logic [11:0] code);
      logic [15:0] rx;
      logic [15:0] fb;
      logic [3:0]  nf;
      logic [4:0]  n;
      logic        ord;
      int          k;
      nf  = (cmd[7:4] == CMD_RESERVED) ? exp_fmt : cmd[3:0];
      n   = len_bits(nf);
      ord = exp_fmt[FMT_LSB_FIRST];  // order was set by an earlier cycle
      RESULT_CODE = code;
      host_u.xfer(cmd, int'(n), last_conv && $urandom_range(1), rx);
      // lsb first output may be spoiled once by a length change
      if (res_ok && (!ord || n == prev_n))
         check("serial out", rx, exp_stream(exp_res, n, ord));
      prev_n  = n;
      exp_fmt = nf;
      repeat (8) @(negedge CLK);
      check("format", FMT_OUT, exp_fmt);
      last_conv = 1'b0;
      if (cmd[7:4] == CMD_RESERVED)
      begin
         repeat (300) @(negedge CLK);  // any conversion is over by now
         res_ok = 1'b0;
      end
      else if (cmd[7:4] == CMD_SLEEP)
      begin
         check("sleep", SOFTWARE_SLEEP, 1);
         check("eoc in sleep", EOC, 1);
      end
      else
      begin
         check("eoc and sample", {EOC, SAMPLE}, 0);
         check("input select", MUX_SEL, cmd[7:4]);
         k = 0;
         while (EOC !== 1'b1 && k < 400)
         begin
            @(negedge CLK);
            k++;
         end
         check("eoc rise", EOC, 1);
         check("awake", SOFTWARE_SLEEP, 0);
         exp_res   = code ^ {nf[FMT_TWOS], 11'h000};
         res_ok    = 1'b1;
         last_conv = 1'b1;
         fb        = exp_stream(exp_res, n, nf[FMT_LSB_FIRST]);
         check("first bit at eoc", SDO_O, fb[0]);
         check("output enable", SDO_OE_N, 0);
      end
   endtask

   initial
   begin
      void'($urandom(48));
      RST = 1'b1;
      RESULT_CODE = 12'h000;
      exp_fmt = FMT_RESET;
      res_ok = 1'b0;
      last_conv = 1'b0;
      prev_n = BITS_12;
      repeat (5) @(negedge CLK);
      RST = 1'b0;
      @(negedge CLK);
      check("reset state", {EOC, SDO_OE_N, SOFTWARE_SLEEP, FMT_OUT}, 16'h0070);
      check("reset outputs", {SAMPLE, MUX_SEL}, 0);
      // corners: result extremes, every length, order and coding, sleep, reserved
      run(8'h00, 12'h000);
      run(8'h14, 12'hfff);
      run(8'h2c, 12'h800);
      run(8'hbd, 12'h800);
      run(8'hc2, 12'hfff);
      run(8'hd6, 12'h001);
      run(8'he0, 12'h5a5);
      run(8'h3f, 12'h7ff);
      run(8'hf5, 12'h123);
      run(8'ha1, 12'h800);
      for (int i = 0; i < 16; i++)
         run({i[3:0], 4'($urandom)}, 12'($urandom));
      for (int i = 0; i < 12; i++)
         run(8'($urandom), 12'($urandom));
      tally_and_finish();
   end
endmodule
